//--- rtl/psi_pkg.sv
// constants and types of the program counter, return stack and indirect address block
// Operation
// - pc is 13 bits, low byte plus five high
// - low pc byte readable and writable by software
// - upper pc bits never directly software accessible
// - every reset clears the whole pc
// - low byte write loads high bits from latch
// - call/goto take top two bits from latch
// - eight-entry, 13-bit return stack, outside memory
// - stack pointer hidden from software entirely
// - push pc on call and interrupt branch
// - taken interrupt jumps to vector 0004h
// - return variants pop stack into pc
// - push and pop leave latch untouched
// - stack wraps, ninth push overwrites first
// - no overflow or underflow status anywhere
// - indirect port is address without storage
// - indirect port accesses location at pointer
// - indirect read of indirect port gives 00h
// - indirect write of indirect port stores nothing
// - nine-bit address is bank bit over pointer
package psi_pkg;
  // ****************
  // widths
  // ****************
  localparam int PC_W = 13;
  localparam int PCL_W = 8;
  localparam int PCH_W = 5;
  localparam int TGT_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int DATA_W = 8;
  localparam int DADDR_W = 9;
  localparam int DIR_W = 7;
  localparam int APB_AW = 8;
  // ****************
  // fixed values
  // ****************
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [4:0] LATCH_RESET = 5'h00;
  localparam logic [7:0] FSR_RESET = 8'h00;
  localparam logic [6:0] INDIRECT_PORT = 7'h00;
  localparam logic [7:0] NULL_READ = 8'h00;
  localparam int LATCH_TOP_HI = 4;
  localparam int LATCH_TOP_LO = 3;
  localparam int BANK_BIT_POS = 0;
  // ****************
  // register offsets
  // ****************
  localparam logic [7:0] OFS_PCL = 8'h00;
  localparam logic [7:0] OFS_LATCH = 8'h04;
  localparam logic [7:0] OFS_FSR = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0c;
  localparam logic [7:0] OFS_INDIRECT = 8'h10;
  // ****************
  // types
  // ****************
  typedef enum logic [2:0] {
    PSI_OP_NONE = 3'h0,
    PSI_OP_STEP = 3'h1,
    PSI_OP_GOTO = 3'h2,
    PSI_OP_CALL = 3'h3,
    PSI_OP_RETURN = 3'h4,
    PSI_OP_PCL_WRITE = 3'h5
  } psi_op_t;
  typedef enum logic [1:0] {
    PSI_AP_IDLE = 2'b00,
    PSI_AP_ISSUE = 2'b01,
    PSI_AP_WAIT = 2'b11,
    PSI_AP_DONE = 2'b10
  } psi_ap_state_t;
endpackage

//--- rtl/psi_stack_if.sv
// link between the core logic and its return stack
`timescale 1ns/100ps
interface psi_stack_if #(parameter int W = 13);
  logic push;
  logic pop;
  logic [W-1:0] push_data;
  logic [W-1:0] top_data;
  modport owner (output push, output pop, output push_data, input top_data);
  modport stack (input push, input pop, input push_data, output top_data);
endinterface

//--- rtl/psi_stack.sv
// circular return stack
`timescale 1ns/100ps
module psi_stack #(
  parameter int DEPTH = psi_pkg::STACK_DEPTH,
  parameter int W = psi_pkg::PC_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // stack side
  psi_stack_if.stack sif
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] ptr_r;
  logic [PW-1:0] top_idx;
  assign top_idx = ptr_r - {{(PW-1){1'b0}}, 1'b1};
  assign sif.top_data = mem[top_idx];
  // ****************
  // pointer
  // ****************
  // pointer wraps freely
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_r <= '0;
    end else if (sif.push && !sif.pop) begin
      ptr_r <= ptr_r + {{(PW-1){1'b0}}, 1'b1};
    end else if (sif.pop && !sif.push) begin
      ptr_r <= top_idx;
    end
  end
  // ****************
  // storage
  // ****************
  // no overflow or underflow flag
  always_ff @(posedge clock) begin
    if (sif.push) begin
      mem[ptr_r] <= sif.push_data;
    end
  end
endmodule

//--- rtl/psi_core.sv
// program counter, return stack control and indirect data addressing
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps
module psi_core (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // decoder operations
  input wire psi_pkg::psi_op_t op_kind,
  input wire logic [10:0] op_target,
  input wire logic [7:0] op_pcl_data,
  input wire logic irq_req,
  input wire logic global_interrupt_enable,
  // program counter
  output logic [12:0] pc,
  output logic irq_taken,
  // execute stage data access
  input wire logic dm_req,
  input wire logic dm_we,
  input wire logic [8:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  output logic [7:0] dm_rdata,
  output logic dm_rvalid,
  // data memory
  output logic mem_req,
  output logic mem_we,
  output logic [8:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);
  // ****************
  // declarations
  // ****************
  logic [12:0] pc_r;
  logic [12:0] pc_nxt;
  logic [12:0] step_pc;
  logic [12:0] jump_pc;
  logic [12:0] pcl_pc;
  logic [12:0] apb_pc;
  logic [12:0] push_val;
  logic [4:0] latch_r;
  logic [7:0] fsr_r;
  logic bank_r;
  logic irq_taken_r;
  logic take_irq;
  logic do_push;
  logic do_pop;
  logic op_blocked;
  logic apb_access;
  logic apb_wr;
  logic apb_mapped;
  logic apb_is_ind;
  logic apb_pcl_wr;
  logic [7:0] apb_wbyte;
  logic [31:0] rd_word;
  logic [31:0] prdata_r;
  psi_pkg::psi_ap_state_t ap_state_r;
  psi_pkg::psi_ap_state_t ap_state_nxt;
  logic [8:0] ind_addr;
  logic [8:0] eff_addr;
  logic dm_is_ind;
  logic ind_null;
  logic mem_req_r;
  logic mem_we_r;
  logic [8:0] mem_addr_r;
  logic [7:0] mem_wdata_r;
  logic null_rd_r;
  logic [7:0] dm_rdata_r;
  logic dm_rvalid_r;
  // ****************
  // return stack
  // ****************
  // stack kept outside both memories
  psi_stack_if #(.W(psi_pkg::PC_W)) stk ();
  psi_stack #(
    .DEPTH(psi_pkg::STACK_DEPTH),
    .W(psi_pkg::PC_W)
  ) psi_stack_inst (
    .clock(clock),
    .rst(rst),
    .sif(stk)
  );
  // push on call or taken interrupt
  assign stk.push = do_push;
  assign stk.pop = do_pop;
  assign stk.push_data = push_val;
  // ****************
  // apb handshake
  // ****************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ap_state_r <= psi_pkg::PSI_AP_IDLE;
    end else begin
      ap_state_r <= ap_state_nxt;
    end
  end
  always_comb begin
    ap_state_nxt = ap_state_r;
    unique case (ap_state_r)
      psi_pkg::PSI_AP_IDLE: begin
        if (psel) begin
          ap_state_nxt = psi_pkg::PSI_AP_ISSUE;
        end
      end
      psi_pkg::PSI_AP_ISSUE: begin
        if (!psel) begin
          ap_state_nxt = psi_pkg::PSI_AP_IDLE;
        end else if (penable) begin
          ap_state_nxt = psi_pkg::PSI_AP_WAIT;
        end
      end
      psi_pkg::PSI_AP_WAIT: begin
        if (!psel) begin
          ap_state_nxt = psi_pkg::PSI_AP_IDLE;
        end else begin
          ap_state_nxt = psi_pkg::PSI_AP_DONE;
        end
      end
      psi_pkg::PSI_AP_DONE: begin
        ap_state_nxt = psi_pkg::PSI_AP_IDLE;
      end
    endcase
  end
  // ready two cycles into the access phase
  assign pready = (ap_state_r == psi_pkg::PSI_AP_DONE);
  assign apb_access = psel && penable && pready;
  assign apb_wr = apb_access && pwrite;
  assign apb_wbyte = pwdata[7:0];
  assign apb_is_ind = (paddr == psi_pkg::OFS_INDIRECT);
  always_comb begin
    apb_mapped = 1'b0;
    if (paddr == psi_pkg::OFS_PCL) begin
      apb_mapped = 1'b1;
    end
    if (paddr == psi_pkg::OFS_LATCH) begin
      apb_mapped = 1'b1;
    end
    if (paddr == psi_pkg::OFS_FSR) begin
      apb_mapped = 1'b1;
    end
    if (paddr == psi_pkg::OFS_BANK) begin
      apb_mapped = 1'b1;
    end
    if (apb_is_ind) begin
      apb_mapped = 1'b1;
    end
  end
  assign pslverr = pready && !apb_mapped;
  // ****************
  // register read mux
  // ****************
  always_comb begin
    rd_word = 32'h0000_0000;
    if (paddr == psi_pkg::OFS_PCL) begin
      rd_word = {24'h00_0000, pc_r[7:0]};
    end
    // latch only, never pc high bits
    if (paddr == psi_pkg::OFS_LATCH) begin
      rd_word = {27'h000_0000, latch_r};
    end
    if (paddr == psi_pkg::OFS_FSR) begin
      rd_word = {24'h00_0000, fsr_r};
    end
    if (paddr == psi_pkg::OFS_BANK) begin
      rd_word = {31'h0000_0000, bank_r};
    end
    if (apb_is_ind) begin
      rd_word = {24'h00_0000, psi_pkg::NULL_READ};
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (ap_state_r == psi_pkg::PSI_AP_WAIT && psel && !pwrite) begin
      prdata_r <= rd_word;
    end
  end
  assign prdata = prdata_r;
  // ****************
  // software registers
  // ****************
  // latch changes by software write only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_r <= psi_pkg::LATCH_RESET;
    end else if (apb_wr && paddr == psi_pkg::OFS_LATCH) begin
      latch_r <= pwdata[4:0];
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fsr_r <= psi_pkg::FSR_RESET;
    end else if (apb_wr && paddr == psi_pkg::OFS_FSR) begin
      fsr_r <= pwdata[7:0];
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bank_r <= 1'b0;
    end else if (apb_wr && paddr == psi_pkg::OFS_BANK) begin
      bank_r <= pwdata[psi_pkg::BANK_BIT_POS];
    end
  end
  // ****************
  // program counter
  // ****************
  assign apb_pcl_wr = apb_wr && (paddr == psi_pkg::OFS_PCL);
  assign take_irq = irq_req && global_interrupt_enable;
  assign op_blocked = take_irq || apb_pcl_wr;
  assign step_pc = pc_r + 13'h0001;
  assign jump_pc = {latch_r[psi_pkg::LATCH_TOP_HI:psi_pkg::LATCH_TOP_LO], op_target};
  assign pcl_pc = {latch_r, op_pcl_data};
  assign apb_pc = {latch_r, apb_wbyte};
  assign push_val = take_irq ? pc_r : step_pc;
  assign do_push = take_irq || (!apb_pcl_wr && op_kind == psi_pkg::PSI_OP_CALL);
  assign do_pop = !op_blocked && (op_kind == psi_pkg::PSI_OP_RETURN);
  always_comb begin
    pc_nxt = pc_r;
    if (take_irq) begin
      pc_nxt = psi_pkg::IRQ_VECTOR;
    end else if (apb_pcl_wr) begin
      pc_nxt = apb_pc;
    end else begin
      unique case (op_kind)
        psi_pkg::PSI_OP_NONE: begin
          pc_nxt = pc_r;
        end
        psi_pkg::PSI_OP_STEP: begin
          pc_nxt = step_pc;
        end
        psi_pkg::PSI_OP_GOTO, psi_pkg::PSI_OP_CALL: begin
          pc_nxt = jump_pc;
        end
        psi_pkg::PSI_OP_RETURN: begin
          pc_nxt = stk.top_data;
        end
        psi_pkg::PSI_OP_PCL_WRITE: begin
          pc_nxt = pcl_pc;
        end
        default: begin
          pc_nxt = pc_r;
        end
      endcase
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pc_r <= psi_pkg::PC_RESET;
    end else begin
      pc_r <= pc_nxt;
    end
  end
  assign pc = pc_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_taken_r <= 1'b0;
    end else begin
      irq_taken_r <= take_irq;
    end
  end
  assign irq_taken = irq_taken_r;
  // ****************
  // indirect addressing
  // ****************
  // nine-bit indirect address
  assign ind_addr = {bank_r, fsr_r};
  assign dm_is_ind = (dm_addr[psi_pkg::DIR_W-1:0] == psi_pkg::INDIRECT_PORT);
  assign ind_null = dm_is_ind && (ind_addr[psi_pkg::DIR_W-1:0] == psi_pkg::INDIRECT_PORT);
  assign eff_addr = dm_is_ind ? ind_addr : dm_addr;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_req_r <= 1'b0;
    end else begin
      mem_req_r <= dm_req && !ind_null;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_we_r <= 1'b0;
    end else begin
      mem_we_r <= dm_req && dm_we && !ind_null;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_addr_r <= 9'h000;
    end else begin
      mem_addr_r <= eff_addr;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_wdata_r <= 8'h00;
    end else begin
      mem_wdata_r <= dm_wdata;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      null_rd_r <= 1'b0;
    end else begin
      null_rd_r <= dm_req && !dm_we && ind_null;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dm_rdata_r <= 8'h00;
    end else if (null_rd_r) begin
      dm_rdata_r <= psi_pkg::NULL_READ;
    end else if (mem_req_r && !mem_we_r) begin
      dm_rdata_r <= mem_rdata;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dm_rvalid_r <= 1'b0;
    end else begin
      dm_rvalid_r <= null_rd_r || (mem_req_r && !mem_we_r);
    end
  end
  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign dm_rdata = dm_rdata_r;
  assign dm_rvalid = dm_rvalid_r;
endmodule

//--- verif/psi_mem_model.sv
// data memory model
`timescale 1ns/100ps
module psi_mem_model (
  // memory port
  input logic mem_req,
  input logic [8:0] mem_addr,
  output logic [7:0] mem_rdata
);
  // idle port shows a changing pattern
  assign mem_rdata = mem_req ? mem_addr[7:0] ^ 8'h5a : ~mem_addr[7:0];
endmodule

//--- verif/psi_monitor.sv
// port checker of the pc block
`timescale 1ns/100ps
module psi_monitor (
  // watched ports
  input logic clock,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic pready,
  input psi_pkg::psi_op_t op_kind,
  input logic [10:0] op_target,
  input logic [7:0] op_pcl_data,
  input logic irq_req,
  input logic global_interrupt_enable,
  input logic [12:0] pc,
  input logic irq_taken
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_pc_clear: assert property ($fell(rst) |-> pc == 13'h0)
    else $error("clear");
  a_pc_step: assert property (op_kind == 3'h1 && !irq_req && !pready |=> pc == $past(pc) + 13'h1)
    else $error("step");
  a_jump_low: assert property (op_kind inside {3'h2, 3'h3} && !irq_req && !pready |=>
    pc[10:0] == $past(op_target)) else $error("jump");
  a_pcl_low: assert property (op_kind == 3'h5 && !irq_req && !pready |=>
    pc[7:0] == $past(op_pcl_data)) else $error("pcl");
  a_irq_vec: assert property (irq_req && global_interrupt_enable |=> pc == 13'h4)
    else $error("vector");
  a_irq_mask: assert property (!global_interrupt_enable |=> !irq_taken)
    else $error("mask");
  a_pc_hold: assert property (op_kind == 3'h0 && !irq_req && !psel |=> $stable(pc))
    else $error("hold");
  a_apb_ready: assert property (psel && !penable |-> ##[1:16] pready)
    else $error("ready");
  cover property (op_kind == 3'h3);
  cover property (op_kind == 3'h4);
  cover property (irq_taken);
endmodule
bind psi_core psi_monitor psi_monitor_inst (.*);

//--- verif/tb_top.sv
// bench of the pc block
`timescale 1ns/100ps
module tb_top;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, irq_req = 0;
  logic global_interrupt_enable = 0, pready, pslverr, irq_taken, dm_rvalid, mem_req, mem_we;
  logic dm_req = 0, dm_we = 0, se;
  logic [8:0] dm_addr = 0;
  logic [7:0] dm_wdata = 0;
  logic [7:0] paddr = 0, op_pcl_data = 0, dm_rdata, mem_wdata, mem_rdata;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [10:0] op_target = 0;
  logic [12:0] pc;
  logic [8:0] mem_addr;
  logic [26:0] rows [7] = '{{3'h1, 11'h0, 13'h1}, {3'h2, 11'h123, 13'h1923},
    {3'h1, 11'h0, 13'h1924}, {3'h3, 11'h7ff, 13'h1fff}, {3'h5, 11'h34, 13'h1a34},
    {3'h4, 11'h0, 13'h1925}, {3'h0, 11'h0, 13'h4}};
  psi_pkg::psi_op_t op_kind = psi_pkg::PSI_OP_NONE;
  int errors = 0, checks_done = 0;
  always #5 clock = ~clock;
  psi_core psi_core_inst (.*);
  psi_mem_model psi_mem_model_inst (.*);
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] s);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic dm(input logic w, input logic [8:0] a, input logic go, input logic [8:0] ea,
      input logic [7:0] e);
    dm_req <= 1;
    dm_we <= w;
    dm_addr <= a;
    dm_wdata <= 8'h3c;
    @(posedge clock) dm_req <= 0;
    @(negedge clock) chk("mem_req", 13'(go), 13'(mem_req));
    chk("mem_we", 13'(go && w), 13'(mem_we));
    if (go) chk("mem_addr", 13'(ea), 13'(mem_addr));
    if (go && w) chk("mem_wdata", 13'h3c, 13'(mem_wdata));
    @(posedge clock);
    @(negedge clock) chk("dm_rvalid", 13'(!w), 13'(dm_rvalid));
    if (!w) chk("dm_rdata", 13'(e), 13'(dm_rdata));
    @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  task automatic op(input logic [26:0] r);
    op_kind <= psi_pkg::psi_op_t'(r[26:24]);
    op_target <= r[23:13];
    op_pcl_data <= r[20:13];
    irq_req <= r[26:24] == 3'h0;
    @(posedge clock) op_kind <= psi_pkg::PSI_OP_NONE;
    irq_req <= 0;
    @(negedge clock) chk("pc", r[12:0], pc);
    chk("irq_taken", 13'(r[26:24] == 3'h0 && global_interrupt_enable), 13'(irq_taken));
    @(posedge clock);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 0;
    @(negedge clock) chk("pc", 13'h0, pc);
    @(posedge clock) apb(1, psi_pkg::OFS_LATCH, 32'h1a);
    global_interrupt_enable <= 1;
    foreach (rows[i]) op(rows[i]);
    apb(1, psi_pkg::OFS_PCL, 32'h77);
    apb(0, psi_pkg::OFS_PCL, 32'h0);
    chk("prdata", 13'h77, {5'h0, rd[7:0]});
    for (int i = 1; i < 10; i++) op({3'h3, 11'(i), 13'h1800 + 13'(i)});
    for (int j = 0; j < 9; j++) op({3'h4, 11'h0, j < 8 ? 13'h1809 - 13'(j) : 13'h1809});
    apb(1, psi_pkg::OFS_FSR, 32'h20);
    apb(1, psi_pkg::OFS_BANK, 32'h1);
    dm(0, 9'h000, 1, 9'h120, 8'h7a);
    dm(1, 9'h080, 1, 9'h120, 8'h0);
    dm(0, 9'h035, 1, 9'h035, 8'h6f);
    apb(1, psi_pkg::OFS_FSR, 32'h80);
    dm(0, 9'h000, 0, 9'h0, 8'h0);
    dm(1, 9'h000, 0, 9'h0, 8'h0);
    apb(0, psi_pkg::OFS_INDIRECT, 32'h0);
    chk("prdata", 13'h0, 13'(rd));
    apb(0, 8'h20, 32'h0);
    chk("pslverr", 13'h1, 13'(se));
    global_interrupt_enable <= 0;
    op({3'h0, 11'h0, 13'h1809});
    rst <= 1;
    @(posedge clock) rst <= 0;
    @(negedge clock) chk("pc", 13'h0, pc);
    @(posedge clock) apb(0, psi_pkg::OFS_LATCH, 32'h0);
    chk("latch", 13'h0, 13'(rd));
    op({3'h2, 11'h5, 13'h5});
    end_of_test;
  end
  initial begin
    #30000;
    errors++;
    end_of_test;
  end
endmodule
